//--- hw/dcsw_pkg.sv
// constants, command layout and states of the drive control and status word block
// ****************************************************************
// Behaviour
// - command bit 0 low: ramp down on normal time, drop drive at standstill
// - bit 0 rising edge: go ready; energize motor only if bit 3 high
// - bit 1 low: de-energize at once and coast; high permits switch-on
// - bit 2 low: quick stop on quick ramp to standstill; high permits switch-on
// - bit 3 low: cancel output pulses at once; high allows pulses and switch-on
// - bit 4 low: ramp generator output forced to zero at once
// - bit 5 low: ramp generator output held while running; high: it tracks the setpoint
// - bit 6 low: brake on ramp-down time; high: accelerate toward setpoint
// - bit 7 rising edge acknowledges faults; with on still set, enter lockout
// - bit 10 low: fieldbus process data ignored; high: accepted for control
// - bit 11 high inverts the setpoint sign to reverse direction
// - bit 13 raises, bit 14 lowers the stored motor potentiometer setpoint
// - status bit 1: ready, running or in ramp stop, and no fault present
// - status bit 2: operation enabled, motor follows setpoint
// - status bit 3: fault present; master clears it by pulsing bit 7
// - status bit 4: no coast stop; status bit 5: no quick stop
// - status bit 6 lockout refuses switch-on until stop then new on
// - status bit 7: alarm present, motor keeps running, no acknowledge
// - status bit 9 requests master to take over control
// - status bits 13 and 15: motor overtemp and converter overload, active low
// - status bit 14 high for positive speed, low for negative
// ****************************************************************
package dcsw_pkg;

  // command word layout, bit 15 first
  typedef struct packed {
    logic       rsv15;
    logic       mop_down;
    logic       mop_up;
    logic       rsv12;
    logic       reverse;
    logic       plc_ctrl;
    logic [1:0] rsv9_8;
    logic       fault_ack;
    logic       setpoint_en;
    logic       ramp_run;
    logic       ramp_en;
    logic       op_enable;
    logic       quick_stop_n;
    logic       coast_stop_n;
    logic       ramp_stop_n;
  } dcsw_cmd_s;

  // drive conditions reported into the status word
  typedef struct packed {
    logic supply_ok;
    logic init_done;
    logic alarm;
    logic speed_in_tol;
    logic ctrl_request;
    logic cmp_speed_reached;
    logic torque_not_limited;
    logic motor_overtemp;
    logic conv_overload;
  } dcsw_cond_s;

  // switching states
  typedef enum logic [2:0] {
    ST_LOCKOUT,
    ST_READY_START,
    ST_READY,
    ST_RUN,
    ST_RAMP_STOP,
    ST_QUICK_STOP,
    ST_FAULT
  } dcsw_state_e;

  // reset values and reserved mask
  localparam logic [15:0] CMD_RESET    = 16'h0000;
  localparam logic [15:0] CMD_RSV_MASK = 16'h6CFF;
  localparam logic [15:0] STAT_RESET   = 16'h0000;
  localparam logic [15:0] MOP_RESET    = 16'h0000;

  // status bit positions
  localparam int ST_B_RDY_START = 0;
  localparam int ST_B_READY     = 1;
  localparam int ST_B_OP_EN     = 2;
  localparam int ST_B_FAULT     = 3;
  localparam int ST_B_NO_COAST  = 4;
  localparam int ST_B_NO_QSTOP  = 5;
  localparam int ST_B_LOCKOUT   = 6;
  localparam int ST_B_ALARM     = 7;
  localparam int ST_B_SPD_TOL   = 8;
  localparam int ST_B_CTRL_REQ  = 9;
  localparam int ST_B_CMP_SPD   = 10;
  localparam int ST_B_TRQ_OK    = 11;
  localparam int ST_B_MOT_TEMP  = 13;
  localparam int ST_B_CW        = 14;
  localparam int ST_B_CONV_OVL  = 15;

  // ramp and potentiometer stepping
  localparam int          CLK_PERIOD_NS  = 40;
  localparam int          RAMP_TICK_NS   = 1000;
  localparam int          RAMP_TICK_CYC  = (RAMP_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] RAMP_UP_STEP   = 16'h0010;
  localparam logic [15:0] RAMP_DOWN_STEP = 16'h0010;
  localparam logic [15:0] QSTOP_STEP     = 16'h0040;
  localparam logic [15:0] MOP_STEP       = 16'h0001;
  localparam logic [15:0] MOP_MAX        = 16'h7FFF;
  localparam logic [15:0] MOP_MIN        = 16'h8001;

endpackage

//--- hw/dcsw_ramp.sv
// ramp generator that steps its output toward a target on tick enables
module dcsw_ramp
  import dcsw_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // control
  input  wire logic               step_en,
  input  wire logic               force_zero,
  input  wire logic               hold,
  input  wire logic signed [15:0] target,
  input  wire logic        [15:0] step_up,
  input  wire logic        [15:0] step_down,
  // output
  output logic signed      [15:0] ramp_out
);

  // one step from cur toward tgt, never overshooting
  function automatic logic signed [15:0] approach(input logic signed [15:0] cur,
                                                  input logic signed [15:0] tgt,
                                                  input logic [15:0] stp);
    logic signed [16:0] diff;
    logic        [16:0] mag;
    diff = 17'(tgt) - 17'(cur);
    mag  = diff[16] ? 17'(-diff) : 17'(diff);
    if (mag <= {1'b0, stp}) begin
      approach = tgt;
    end else if (diff[16]) begin
      approach = 16'(17'(cur) - {1'b0, stp});
    end else begin
      approach = 16'(17'(cur) + {1'b0, stp});
    end
  endfunction

  logic accel;

  // away from zero accelerates, toward zero brakes
  assign accel = (target > ramp_out) ? !ramp_out[15] : (ramp_out[15] || ramp_out == 16'sh0);

  // output register
  always_ff @(posedge clk) begin
    if (rst) begin
      ramp_out <= 16'sh0000;
    end else if (force_zero) begin
      ramp_out <= 16'sh0000;
    end else if (step_en && !hold) begin
      ramp_out <= approach(ramp_out, target, accel ? step_up : step_down);
    end
  end

endmodule // dcsw_ramp

//--- hw/dcsw_top.sv
// drive control word decoder, switching sequence and status word assembly
module dcsw_top
  import dcsw_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // fieldbus command word
  input  wire logic        [15:0] drive_command_word,
  input  wire logic               cmd_valid,
  // fieldbus status word
  output logic             [15:0] drive_state_word,
  // drive conditions and events
  input  wire dcsw_cond_s         cond,
  input  wire logic               fault_event,
  input  wire logic               fault_active,
  input  wire logic signed [15:0] speed_actual,
  input  wire logic signed [15:0] setpoint,
  // power stage and setpoint path
  output logic                    pulse_enable,
  output logic signed      [15:0] ramp_out,
  output logic signed      [15:0] motor_potentiometer
);

  // ****************************************************************
  // command capture
  // ****************************************************************

  // a word without fieldbus control leaves the previous one in force,
  // so a master dropping control does not stop the drive
  dcsw_cmd_s   cmd_reg;
  logic        on_prev_reg;
  logic        ack_prev_reg;
  logic        on_rise;
  logic        ack_rise;

  // process data only latched while the word itself asks for fieldbus control
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_reg      <= dcsw_cmd_s'(CMD_RESET);
    end else if (cmd_valid) begin
      // reserved bits masked here so no later decode sees them
      if (drive_command_word[10]) begin
        cmd_reg <= dcsw_cmd_s'(drive_command_word & CMD_RSV_MASK);
      end
    end
  end

  // previous values reset to the idle level, so no false edge after
  // reset; an edge needs the low word latched for at least one cycle
  // edge detection on on-command and fault acknowledge
  always_ff @(posedge clk) begin
    if (rst) begin
      on_prev_reg  <= 1'b0;
      ack_prev_reg <= 1'b0;
    end else begin
      on_prev_reg  <= cmd_reg.ramp_stop_n;
      ack_prev_reg <= cmd_reg.fault_ack;
    end
  end

  assign on_rise  = cmd_reg.ramp_stop_n && !on_prev_reg;
  assign ack_rise = cmd_reg.fault_ack && !ack_prev_reg;

  // ****************************************************************
  // fault latch
  // ****************************************************************

  logic fault_reg;

  // a standing fault keeps the latch set; its acknowledge is lost
  // and must be repeated once the fault has gone
  // a new fault wins over an acknowledge in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      fault_reg <= 1'b0;
    end else if (fault_event || fault_active) begin
      fault_reg <= 1'b1;
    end else if (ack_rise) begin
      fault_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // tick divider for ramp and potentiometer stepping
  // ****************************************************************

  // counter wide enough for the full tick count
  localparam int TICK_W = $clog2(RAMP_TICK_CYC + 1);

  logic [TICK_W-1:0] tick_cnt_reg;
  logic              tick_reg;

  // count rounded up to whole clocks: steps never come too fast;
  // ramp and potentiometer share this tick
  // one-cycle enable every RAMP_TICK_CYC clocks
  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
    end else if (tick_cnt_reg == TICK_W'(RAMP_TICK_CYC - 1)) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + TICK_W'(1);
      tick_reg     <= 1'b0;
    end
  end

  // ****************************************************************
  // switching sequence
  // ****************************************************************

  dcsw_state_e state_reg;
  dcsw_state_e state_next;
  logic        powered;
  logic        standstill;

  // powered gates the step from lockout to ready to start; standstill is judged on
  // the ramp output, so a stop ends even without speed feedback
  assign powered    = cond.supply_ok && cond.init_done;
  assign standstill = (ramp_out == 16'sh0000);

  // priority: coast stop, quick stop, inhibit, normal stop;
  // the fault latch overrides the whole decision at the end
  // next state from command bits, fault and standstill
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_LOCKOUT: begin
        // leaves only after the on command was dropped
        if (powered && !cmd_reg.ramp_stop_n && cmd_reg.coast_stop_n &&
            cmd_reg.quick_stop_n) begin
          state_next = ST_READY_START;
        end
      end
      ST_READY_START: begin
        // waits for a rising edge of the on command
        if (!powered || !cmd_reg.coast_stop_n || !cmd_reg.quick_stop_n) begin
          state_next = ST_LOCKOUT;
        end else if (on_rise) begin
          state_next = ST_READY;
        end
      end
      ST_READY: begin
        // on seen; pulses wait for operation enable
        if (!cmd_reg.coast_stop_n || !cmd_reg.quick_stop_n) begin
          state_next = ST_LOCKOUT;
        end else if (!cmd_reg.ramp_stop_n) begin
          state_next = ST_READY_START;
        end else if (cmd_reg.op_enable) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        // pulses on, ramp follows the setpoint
        if (!cmd_reg.coast_stop_n) begin
          state_next = ST_LOCKOUT;
        end else if (!cmd_reg.quick_stop_n) begin
          state_next = ST_QUICK_STOP;
        end else if (!cmd_reg.op_enable) begin
          state_next = ST_READY;
        end else if (!cmd_reg.ramp_stop_n) begin
          state_next = ST_RAMP_STOP;
        end
      end
      ST_RAMP_STOP: begin
        // normal braking, pulses stay on
        if (!cmd_reg.coast_stop_n) begin
          state_next = ST_LOCKOUT;
        end else if (!cmd_reg.quick_stop_n) begin
          state_next = ST_QUICK_STOP;
        end else if (!cmd_reg.op_enable || standstill) begin
          state_next = ST_READY_START;
        end
      end
      ST_QUICK_STOP: begin
        // quick braking, always ends in lockout
        if (!cmd_reg.coast_stop_n || !cmd_reg.op_enable || standstill) begin
          state_next = ST_LOCKOUT;
        end
      end
      ST_FAULT: begin
        // held until the latch is acknowledged
        if (!fault_reg) begin
          // acknowledged: still-set on command forces lockout
          state_next = cmd_reg.ramp_stop_n ? ST_LOCKOUT : ST_READY_START;
        end
      end
      default: begin
        state_next = ST_LOCKOUT;
      end
    endcase
    if (fault_reg) begin
      state_next = ST_FAULT;
    end
  end

  // lockout after reset forces a stop then on before switch-on
  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_LOCKOUT;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // power stage
  // ****************************************************************

  logic drive_state;

  // next state lets pulses drop on the edge at which a coast stop
  // or inhibit is decoded, the same edge at which the state register shows it
  // pulses only in driving states with operation enabled
  assign drive_state = (state_next == ST_RUN) || (state_next == ST_RAMP_STOP) ||
                       (state_next == ST_QUICK_STOP);

  always_ff @(posedge clk) begin
    if (rst) begin
      pulse_enable <= 1'b0;
    end else begin
      pulse_enable <= drive_state && cmd_reg.op_enable && cmd_reg.coast_stop_n;
    end
  end

  // ****************************************************************
  // setpoint path and ramp generator
  // ****************************************************************

  logic signed [15:0] setpoint_dir;
  logic signed [15:0] ramp_target;
  logic        [15:0] down_step;
  logic               ramp_zero;
  logic               ramp_hold;

  // the most negative setpoint has no positive twin: keep
  // setpoints inside the potentiometer limits
  // direction reversal by sign inversion
  assign setpoint_dir = cmd_reg.reverse ? 16'(-setpoint) : setpoint;

  // target is the setpoint only while running with setpoint enabled
  always_comb begin
    if (state_reg == ST_RUN && cmd_reg.setpoint_en) begin
      ramp_target = setpoint_dir;
    end else begin
      ramp_target = 16'sh0000;
    end
  end

  // the ramp picks up or down step from its direction of travel,
  // so only the braking step changes with the stop kind
  // quick stop brakes on its own step
  assign down_step = (state_reg == ST_QUICK_STOP) ? QSTOP_STEP : RAMP_DOWN_STEP;

  // a stopped power stage leaves the ramp at zero
  assign ramp_zero = !cmd_reg.ramp_en || !pulse_enable;
  assign ramp_hold = !cmd_reg.ramp_run && (state_reg == ST_RUN);

  // ramp_out comes straight from the submodule's flop
  dcsw_ramp u_ramp (
    .clk        (clk),
    .rst        (rst),
    .step_en    (tick_reg),
    .force_zero (ramp_zero),
    .hold       (ramp_hold),
    .target     (ramp_target),
    .step_up    (RAMP_UP_STEP),
    .step_down  (down_step),
    .ramp_out   (ramp_out)
  );

  // ****************************************************************
  // motor potentiometer
  // ****************************************************************

  // both directions at once cancel; the value survives stops
  // and faults and is cleared only by reset
  // raise or lower stored setpoint on each tick, saturating
  always_ff @(posedge clk) begin
    if (rst) begin
      motor_potentiometer <= MOP_RESET;
    end else if (tick_reg && (cmd_reg.mop_up != cmd_reg.mop_down)) begin
      if (cmd_reg.mop_up && motor_potentiometer < $signed(MOP_MAX)) begin
        motor_potentiometer <= motor_potentiometer + $signed(MOP_STEP);
      end else if (cmd_reg.mop_down && motor_potentiometer > $signed(MOP_MIN)) begin
        motor_potentiometer <= motor_potentiometer - $signed(MOP_STEP);
      end
    end
  end

  // ****************************************************************
  // status word
  // ****************************************************************

  logic [15:0] stat_next;

  // recomputed each cycle, one clock behind its causes; alarm and
  // thermal bits pass unlatched; bit 12 is reserved and stays low
  // assemble status bits from sequence state and drive conditions
  always_comb begin
    stat_next = STAT_RESET;
    stat_next[ST_B_RDY_START] = powered && !pulse_enable &&
                                (state_reg == ST_READY_START || state_reg == ST_READY);
    stat_next[ST_B_READY]     = (state_reg == ST_READY || state_reg == ST_RUN ||
                                 state_reg == ST_RAMP_STOP) && !fault_reg;
    stat_next[ST_B_OP_EN]     = (state_reg == ST_RUN) && pulse_enable;
    stat_next[ST_B_FAULT]     = fault_reg;
    stat_next[ST_B_NO_COAST]  = cmd_reg.coast_stop_n;
    stat_next[ST_B_NO_QSTOP]  = cmd_reg.quick_stop_n && (state_reg != ST_QUICK_STOP);
    stat_next[ST_B_LOCKOUT]   = (state_reg == ST_LOCKOUT);
    stat_next[ST_B_ALARM]     = cond.alarm;
    stat_next[ST_B_SPD_TOL]   = cond.speed_in_tol;
    stat_next[ST_B_CTRL_REQ]  = cond.ctrl_request;
    stat_next[ST_B_CMP_SPD]   = cond.cmp_speed_reached;
    stat_next[ST_B_TRQ_OK]    = cond.torque_not_limited;
    stat_next[ST_B_MOT_TEMP]  = !cond.motor_overtemp;
    stat_next[ST_B_CW]        = !speed_actual[15] && (speed_actual != 16'sh0000);
    stat_next[ST_B_CONV_OVL]  = !cond.conv_overload;
  end

  // registered so the fieldbus always reads a settled word
  // status register
  always_ff @(posedge clk) begin
    if (rst) begin
      drive_state_word <= STAT_RESET;
    end else begin
      drive_state_word <= stat_next;
    end
  end

endmodule // dcsw_top

//--- test/dcsw_properties.sv
// concurrent checks on the ports of the drive control and status word block
module dcsw_props
  import dcsw_pkg::*;
(
  // clock and reset
  input wire logic               clk,
  input wire logic               rst,
  // command word
  input wire logic        [15:0] drive_command_word,
  input wire logic               cmd_valid,
  // status word, conditions and events
  input wire logic        [15:0] drive_state_word,
  input wire dcsw_cond_s         cond,
  input wire logic               fault_event,
  input wire logic               fault_active,
  input wire logic signed [15:0] speed_actual,
  input wire logic signed [15:0] setpoint,
  // power stage and setpoint path
  input wire logic               pulse_enable,
  input wire logic signed [15:0] ramp_out,
  input wire logic signed [15:0] motor_potentiometer
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [15:0] cq_reg;

  // shadow of the command word in force (bit 10 gates acceptance)
  always_ff @(posedge clk) begin
    if (rst) begin
      cq_reg <= CMD_RESET;
    end else if (cmd_valid && drive_command_word[10]) begin
      cq_reg <= drive_command_word;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  pulse_off_a: assert property ($past(!cq_reg[3]) && !cq_reg[3] |-> !pulse_enable)
    else $error("pulses on with operation inhibited");
  coast_off_a: assert property ($past(!cq_reg[1]) && !cq_reg[1] |-> !pulse_enable)
    else $error("pulses on during coast stop");
  ramp_zero_a: assert property ($past(!cq_reg[4]) && !cq_reg[4] |-> ramp_out == 16'h0000)
    else $error("ramp output not forced to zero");
  stop_flags_a: assert property (!$past(rst) && $stable(cq_reg[2:1]) |->
    drive_state_word[4] == cq_reg[1] && (cq_reg[2] || !drive_state_word[5]))
    else $error("stop flags disagree with command");
  fault_flag_a: assert property (fault_event |-> ##[1:4] drive_state_word[3] && !pulse_enable)
    else $error("fault not reported");
  ready_flag_a: assert property (drive_state_word[0] && !$past(rst) |->
    $past(cond.supply_ok && cond.init_done))
    else $error("ready to start without supply");
  pulse_on_a: assert property ($rose(pulse_enable) |->
    $past(cq_reg[3] && cq_reg[2] && cq_reg[1]) ##[1:2] drive_state_word[2])
    else $error("pulse start without enable");
  mop_up_a: assert property (cq_reg[13] && !cq_reg[14] && $stable(cq_reg[14:13]) |->
    motor_potentiometer >= $past(motor_potentiometer))
    else $error("potentiometer fell while raising");
  cond_bits_a: assert property (!$past(rst) |-> drive_state_word[11:7] ==
    $past({cond.torque_not_limited, cond.cmp_speed_reached, cond.ctrl_request,
           cond.speed_in_tol, cond.alarm}))
    else $error("condition bits not passed through");
  temp_flags_a: assert property (!$past(rst) |-> drive_state_word[13] !=
    $past(cond.motor_overtemp) && drive_state_word[15] != $past(cond.conv_overload))
    else $error("thermal flags not active low");
  speed_dir_a: assert property (!$past(rst) |->
    drive_state_word[14] == ($past(speed_actual) > 16'sh0000))
    else $error("direction flag wrong");

endmodule // dcsw_props

bind dcsw_top dcsw_props dcsw_props_i (
  .clk, .rst, .drive_command_word, .cmd_valid, .drive_state_word, .cond, .fault_event,
  .fault_active, .speed_actual, .setpoint, .pulse_enable, .ramp_out, .motor_potentiometer
);

//--- test/dcsw_master.sv
// fieldbus master model that delivers drive command words
module dcsw_master
  import dcsw_pkg::*;
(
  // clock
  input wire logic  clk,
  // command word out
  output logic [15:0] drive_command_word,
  output logic        cmd_valid
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle bus at start
  initial begin
    drive_command_word = 16'h0000;
    cmd_valid          = 1'b0;
  end

  // one word per cycle; afterwards the bus shows the inverse, never the stale word
  task automatic send(input logic [15:0] w, input logic raw);
    @(posedge clk);
    drive_command_word <= raw ? w : (w & ~16'h9300);
    cmd_valid          <= 1'b1;
    @(posedge clk);
    cmd_valid          <= 1'b0;
    drive_command_word <= ~w;
  endtask

  // fault acknowledge: bit 7 low, then its rising edge
  task automatic ack(input logic [15:0] w);
    send(w & ~16'h0080, 1'b0);
    send(w | 16'h0080, 1'b0);
  endtask

  // leave lockout: a stop word, then a fresh on
  task automatic restart(input logic [15:0] w);
    send(w & ~16'h0001, 1'b0);
    send(w, 1'b0);
  endtask
endmodule // dcsw_master

//--- test/drive_control_status_word_test.sv
// self-checking bench for the drive control and status word block
module drive_control_status_word_test
  import dcsw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam dcsw_cond_s COND_OK = '{supply_ok: 1'b1, init_done: 1'b1, default: 1'b0};

  logic               clk, rst, cmd_valid, fault_event, fault_active, pulse_enable;
  logic        [15:0] drive_command_word, drive_state_word, held;
  logic signed [15:0] speed_actual, setpoint, ramp_out, motor_potentiometer;
  dcsw_cond_s         cond;
  logic        [32:0] exp_q[$];
  logic        [32:0] ent;
  logic        [31:0] rnd;
  int                 n_fail, total_checks;

  // clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  dcsw_master dcsw_master_i (.clk, .drive_command_word, .cmd_valid);

  dcsw_top dcsw_top_i (
    .clk, .rst, .drive_command_word, .cmd_valid, .drive_state_word, .cond, .fault_event,
    .fault_active, .speed_actual, .setpoint, .pulse_enable, .ramp_out, .motor_potentiometer
  );

  // xorshift source
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
    total_checks++;
    if (seen !== want) begin
      n_fail++;
      $display("unexpected at %0t: %s seen %h want %h", $time, what, seen, want);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // note an expected pulse state and masked status word for the monitor
  task automatic expect_st(input logic pe, input logic [15:0] m, input logic [15:0] v);
    @(posedge clk);
    exp_q.push_back({pe, m, v});
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // monitor: oldest note against settled outputs
  always @(negedge clk) begin
    if (exp_q.size() > 0) begin
      ent = exp_q.pop_front();
      check({15'h0000, pulse_enable}, {15'h0000, ent[32]}, "pulse enable");
      check(drive_state_word & ent[31:16], ent[15:0], "status word");
    end
  end

  // watchdog
  initial begin
    wt(20000);
    n_fail++;
    give_verdict;
  end

  // main sequence
  initial begin
    rnd          = 32'he232_ef16;
    rst          = 1'b1;
    fault_event  = 1'b0;
    fault_active = 1'b0;
    speed_actual = 16'h0000;
    setpoint     = 16'h0000;
    cond         = COND_OK;
    wt(20);
    rst <= 1'b0;
    wt(2);
    @(negedge clk);
    check(ramp_out | motor_potentiometer, 16'h0000, "reset outputs");
    expect_st(1'b0, 16'h0077, 16'h0040);
    // switch on, reserved bits set on the wire
    dcsw_master_i.send(16'h0406, 1'b0);
    wt(4);
    expect_st(1'b0, 16'h0047, 16'h0001);
    dcsw_master_i.send(16'h977F, 1'b1);
    wt(6);
    expect_st(1'b1, 16'h0077, 16'h0036);
    dcsw_master_i.send(16'h0000, 1'b0);
    wt(6);
    expect_st(1'b1, 16'h0077, 16'h0036);
    // random conditions and speed pass into the status word
    repeat (8) begin
      rnd = xs(rnd);
      cond <= dcsw_cond_s'({2'b11, rnd[6:0]});
      speed_actual <= rnd[31:16];
      expect_st(1'b1, 16'hFF80, {~rnd[0], $signed(rnd[31:16]) > 16'sh0000, ~rnd[1], 1'b0,
                rnd[2], rnd[3], rnd[4], rnd[5], rnd[6], 7'h00});
    end
    cond <= COND_OK;
    speed_actual <= 16'h0000;
    setpoint <= 16'h0100;
    wt(500);
    @(negedge clk);
    check(ramp_out, 16'h0100, "ramp up");
    @(posedge clk);
    setpoint <= 16'h0200;
    wt(60);
    dcsw_master_i.send(16'h045F, 1'b0);
    wt(4);
    @(negedge clk);
    held = ramp_out;
    wt(100);
    @(negedge clk);
    check(ramp_out, held, "ramp hold");
    dcsw_master_i.send(16'h0C7F, 1'b0);
    wt(1600);
    @(negedge clk);
    check(ramp_out, 16'hFE00, "reversed setpoint");
    dcsw_master_i.send(16'h046F, 1'b0);
    wt(3);
    @(negedge clk);
    check(ramp_out, 16'h0000, "ramp forced zero");
    // potentiometer up then down
    dcsw_master_i.send(16'h247F, 1'b0);
    wt(250);
    @(negedge clk);
    check({15'h0000, motor_potentiometer >= 9 && motor_potentiometer <= 11}, 16'h0001, "pot up");
    dcsw_master_i.send(16'h447F, 1'b0);
    wt(500);
    @(negedge clk);
    check({15'h0000, motor_potentiometer < 0}, 16'h0001, "pot down");
    // inhibit and re-enable operation
    dcsw_master_i.send(16'h0477, 1'b0);
    wt(4);
    expect_st(1'b0, 16'h0047, 16'h0003);
    dcsw_master_i.send(16'h047F, 1'b0);
    wt(6);
    expect_st(1'b1, 16'h0077, 16'h0036);
    // fault, acknowledge refused while active, then accepted
    fault_event <= 1'b1;
    @(posedge clk);
    fault_event <= 1'b0;
    fault_active <= 1'b1;
    wt(5);
    expect_st(1'b0, 16'h004E, 16'h0008);
    dcsw_master_i.ack(16'h047F);
    wt(5);
    expect_st(1'b0, 16'h0008, 16'h0008);
    fault_active <= 1'b0;
    dcsw_master_i.ack(16'h047F);
    wt(5);
    expect_st(1'b0, 16'h004F, 16'h0040);
    dcsw_master_i.send(16'h047F, 1'b0);
    wt(6);
    expect_st(1'b0, 16'h0040, 16'h0040);
    dcsw_master_i.restart(16'h047F);
    wt(6);
    expect_st(1'b1, 16'h0077, 16'h0036);
    // quick stop ends in lockout
    dcsw_master_i.send(16'h047B, 1'b0);
    wt(300);
    expect_st(1'b0, 16'h0060, 16'h0040);
    // ramp stop keeps pulses until standstill
    dcsw_master_i.restart(16'h047F);
    wt(400);
    dcsw_master_i.send(16'h047E, 1'b0);
    wt(4);
    expect_st(1'b1, 16'h0001, 16'h0000);
    wt(800);
    expect_st(1'b0, 16'h0047, 16'h0001);
    // coast stop
    dcsw_master_i.send(16'h047F, 1'b0);
    wt(6);
    dcsw_master_i.send(16'h047D, 1'b0);
    wt(4);
    expect_st(1'b0, 16'h0050, 16'h0040);
    wt(3);
    give_verdict;
  end
endmodule // drive_control_status_word_test
